// [verilog/ddig_regs.svh]
// register offsets, status word layout and operand constants
`ifndef DDIG_REGS_SVH
`define DDIG_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------------
`define DDIG_OFS_DST      8'h00
`define DDIG_OFS_CMD      8'h04
`define DDIG_OFS_PSW      8'h08
`define DDIG_OFS_STATE    8'h0c
`define DDIG_OFS_IRQACK   8'h10

// ----------------------------------------------------------------------
// processor status word bit positions
// ----------------------------------------------------------------------
`define DDIG_BIT_C        0
`define DDIG_BIT_Z        1
`define DDIG_BIT_N        2
`define DDIG_BIT_GIE      3
`define DDIG_BIT_CORE_OFF_BIT   4
`define DDIG_BIT_OSCILLATOR_OFF_BIT   5
`define DDIG_BIT_V        8
`define DDIG_GIE_MASK     16'h0008
`define DDIG_PSW_RST      16'h0000
`define DDIG_DST_RST      16'h0000

// ----------------------------------------------------------------------
// command word fields and state word fields
// ----------------------------------------------------------------------
`define DDIG_CMD_OP_MSB   1
`define DDIG_CMD_OP_LSB   0
`define DDIG_CMD_BYTE     4
`define DDIG_STATE_SHADOW 0
`define DDIG_STATE_PEND   1
`define DDIG_STATE_ACC    2
`define DDIG_ACK_BIT      0

// ----------------------------------------------------------------------
// double-decrement operands and overflow trigger values
// ----------------------------------------------------------------------
`define DDIG_DOUBLE_DECREMENT_OP_W       16'h0002
`define DDIG_DOUBLE_DECREMENT_OP_B       8'h02
`define DDIG_W_OVF_HI     16'h8001
`define DDIG_W_OVF_LO     16'h8000
`define DDIG_B_OVF_HI     8'h81
`define DDIG_B_OVF_LO     8'h80

`endif

// [verilog/ddig_pkg.sv]
// types shared by the double-decrement and interrupt gate design
package ddig_pkg;
  typedef enum logic [1:0] {
    DDIG_OP_NOP  = 2'h0,
    DDIG_OP_DOUBLE_DECREMENT_OP = 2'h1,
    DDIG_OP_IRQ_DISABLE_OP = 2'h2,
    DDIG_OP_IRQ_ENABLE_OP = 2'h3
  } ddig_op_t;
endpackage : ddig_pkg

// [verilog/ddig_double_decrement_op.sv]
// double-decrement arithmetic with status flag update
`timescale 1ns/100ps
`default_nettype none
`include "ddig_regs.svh"

module ddig_double_decrement_op import ddig_pkg::*; (
  input  wire logic [15:0] dst,
  input  wire logic        byte_mode,
  input  wire logic [15:0] psw_in,
  output logic      [15:0] res,
  output logic      [15:0] psw_out
);

  logic [16:0] wdiff;
  logic [8:0]  bdiff;

  // the extra top bit is the borrow out of the subtraction
  assign wdiff = {1'b0, dst} - {1'b0, `DDIG_DOUBLE_DECREMENT_OP_W};
  assign bdiff = {1'b0, dst[7:0]} - {1'b0, `DDIG_DOUBLE_DECREMENT_OP_B};

  // mode bits and unused bits ride through untouched
  always_comb begin
    psw_out = psw_in;
    if (byte_mode) begin
      res = {8'h00, bdiff[7:0]};
      psw_out[`DDIG_BIT_N] = bdiff[7];
      psw_out[`DDIG_BIT_Z] = (dst[7:0] == `DDIG_DOUBLE_DECREMENT_OP_B);
      psw_out[`DDIG_BIT_C] = ~bdiff[8];
      psw_out[`DDIG_BIT_V] = (dst[7:0] == `DDIG_B_OVF_HI) ||
                             (dst[7:0] == `DDIG_B_OVF_LO);
    end else begin
      res = wdiff[15:0];
      psw_out[`DDIG_BIT_N] = wdiff[15];
      psw_out[`DDIG_BIT_Z] = (dst == `DDIG_DOUBLE_DECREMENT_OP_W);
      psw_out[`DDIG_BIT_C] = ~wdiff[16];
      psw_out[`DDIG_BIT_V] = (dst == `DDIG_W_OVF_HI) ||
                             (dst == `DDIG_W_OVF_LO);
    end
  end

endmodule // ddig_double_decrement_op
`default_nettype wire

// [verilog/ddig_mode.sv]
// global interrupt enable clear and set on the status word
`timescale 1ns/100ps
`default_nettype none
`include "ddig_regs.svh"

module ddig_mode import ddig_pkg::*; (
  input  wire logic [15:0] psw_in,
  input  wire ddig_op_t    op,
  output logic      [15:0] psw_out
);

  // a bit clear or bit set with the enable mask; nothing else moves
  always_comb begin
    case (op)
      DDIG_OP_IRQ_DISABLE_OP: psw_out = psw_in & ~`DDIG_GIE_MASK;
      DDIG_OP_IRQ_ENABLE_OP: psw_out = psw_in | `DDIG_GIE_MASK;
      default:      psw_out = psw_in;
    endcase
  end

endmodule // ddig_mode
`default_nettype wire

// [verilog/ddig_top.sv]
// double-decrement and interrupt gate execution unit with apb access
//
// Operation
// - double-decrement subtracts two from word or byte destination
// - negative flag follows sign of the double-decrement result
// - zero flag set only when destination held two beforehand
// - carry cleared when original destination was zero or one, else set
// - word form: overflow set only for original 08001h or 08000h
// - byte form: overflow set only for original 081h or 080h
// - double-decrement keeps oscillator-off, core-off and enable bits
// - interrupt-disable ands status word with inverse of 08h
// - interrupt-disable clears only the enable bit, mode bits kept
// - interrupt-enable ors 08h into the status word
// - interrupt-enable sets only the enable bit, mode bits kept
// - disable and enable leave negative, zero, carry, overflow alone
// - instruction after enable always runs, even with request pending
`timescale 1ns/100ps
`default_nettype none
`include "ddig_regs.svh"

module ddig_top import ddig_pkg::*; (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        IRQ_REQ,
  output logic             IRQ_ACCEPT
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [15:0] dst_reg;
  logic [15:0] psw_reg;
  logic [4:0]  cmd_reg;
  logic        shadow_reg;
  logic        irq_meta_reg;
  logic        irq_pend_reg;
  logic        irq_accept_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  logic [15:0] dst_next;
  logic [15:0] psw_next;
  logic [31:0] rdata_next;
  logic        mapped;
  logic        access;
  logic        fire;
  logic        wr_fire;
  logic        cmd_fire;
  logic        accept_set;
  logic        accept_clr;
  ddig_op_t    cmd_op;
  logic        cmd_byte;
  logic [15:0] double_decrement_op_res;
  logic [15:0] double_decrement_op_psw;
  logic [15:0] mode_psw;

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, so the
  // read mux is sampled once and held steady for the master
  assign access   = PSEL && PENABLE;
  assign fire     = CE && access && pready_reg;
  assign wr_fire  = fire && PWRITE && mapped;
  assign cmd_fire = wr_fire && (PADDR == `DDIG_OFS_CMD);
  assign cmd_op   = ddig_op_t'(PWDATA[`DDIG_CMD_OP_MSB:`DDIG_CMD_OP_LSB]);
  assign cmd_byte = PWDATA[`DDIG_CMD_BYTE];

  always_comb begin
    mapped = 1'b1;
    case (PADDR)
      `DDIG_OFS_DST:    rdata_next = {16'h0000, dst_reg};
      `DDIG_OFS_CMD:    rdata_next = {27'h0000000, cmd_reg};
      `DDIG_OFS_PSW:    rdata_next = {16'h0000, psw_reg};
      `DDIG_OFS_STATE:  rdata_next = {29'h00000000, irq_accept_reg,
                                      irq_pend_reg, shadow_reg};
      `DDIG_OFS_IRQACK: rdata_next = 32'h00000000;
      default: begin
        rdata_next = 32'h00000000;
        mapped     = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else if (CE) begin
      pready_reg  <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !mapped;
      if (access && !pready_reg && !PWRITE) begin
        prdata_reg <= rdata_next;
      end
    end
  end

  // --------------------------------------------------------------------
  // execution units
  // --------------------------------------------------------------------
  ddig_double_decrement_op u_double_decrement_op (
    .dst       (dst_reg),
    .byte_mode (cmd_byte),
    .psw_in    (psw_reg),
    .res       (double_decrement_op_res),
    .psw_out   (double_decrement_op_psw)
  );

  ddig_mode u_mode (
    .psw_in  (psw_reg),
    .op      (cmd_op),
    .psw_out (mode_psw)
  );

  always_comb begin
    dst_next = dst_reg;
    psw_next = psw_reg;
    if (wr_fire && (PADDR == `DDIG_OFS_DST)) begin
      dst_next = PWDATA[15:0];
    end
    if (wr_fire && (PADDR == `DDIG_OFS_PSW)) begin
      psw_next = PWDATA[15:0];
    end
    if (cmd_fire) begin
      case (cmd_op)
        DDIG_OP_DOUBLE_DECREMENT_OP: begin
          dst_next = double_decrement_op_res;
          psw_next = double_decrement_op_psw;
        end
        DDIG_OP_IRQ_DISABLE_OP: psw_next = mode_psw;
        DDIG_OP_IRQ_ENABLE_OP: psw_next = mode_psw;
        default: begin
          dst_next = dst_reg;
          psw_next = psw_reg;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // operand and status word
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dst_reg <= `DDIG_DST_RST;
    end else if (CE) begin
      dst_reg <= dst_next;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      psw_reg <= `DDIG_PSW_RST;
      cmd_reg <= 5'h00;
    end else if (CE) begin
      psw_reg <= psw_next;
      if (cmd_fire) begin
        cmd_reg <= PWDATA[4:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // interrupt gate
  // --------------------------------------------------------------------
  // the request pin is asynchronous; only the second stage is looked at
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_meta_reg <= 1'b0;
      irq_pend_reg <= 1'b0;
    end else if (CE) begin
      irq_meta_reg <= IRQ_REQ;
      irq_pend_reg <= irq_meta_reg;
    end
  end

  // the shadow holds off acceptance until the instruction after the
  // enable has executed; every command write counts as one instruction
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shadow_reg <= 1'b0;
    end else if (CE && cmd_fire) begin
      shadow_reg <= (cmd_op == DDIG_OP_IRQ_ENABLE_OP);
    end
  end

  assign accept_set = irq_pend_reg && psw_reg[`DDIG_BIT_GIE] &&
                      !shadow_reg;
  assign accept_clr = wr_fire && (PADDR == `DDIG_OFS_IRQACK) &&
                      PWDATA[`DDIG_ACK_BIT];

  // a new acceptance in the clearing cycle wins over the clear
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_accept_reg <= 1'b0;
    end else if (CE) begin
      if (accept_set) begin
        irq_accept_reg <= 1'b1;
      end else if (accept_clr) begin
        irq_accept_reg <= 1'b0;
      end
    end
  end

  assign PRDATA     = prdata_reg;
  assign PREADY     = pready_reg;
  assign PSLVERR    = pslverr_reg;
  assign IRQ_ACCEPT = irq_accept_reg;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_exec(ddig_op_t o, logic b);
    cmd_fire && (cmd_op == o) && (cmd_byte == b);
  endsequence

  sequence s_exec_any(ddig_op_t o);
    cmd_fire && (cmd_op == o);
  endsequence

  a_double_decrement_op_word_res: assert property (
    s_exec(DDIG_OP_DOUBLE_DECREMENT_OP, 1'b0) |=>
      (dst_reg == 16'($past(dst_reg) - `DDIG_DOUBLE_DECREMENT_OP_W)))
    else $error("word double-decrement result wrong");

  a_double_decrement_op_byte_res: assert property (
    s_exec(DDIG_OP_DOUBLE_DECREMENT_OP, 1'b1) |=>
      (dst_reg[7:0] == 8'($past(dst_reg[7:0]) - `DDIG_DOUBLE_DECREMENT_OP_B)))
    else $error("byte double-decrement result wrong");

  a_double_decrement_op_neg: assert property (
    s_exec_any(DDIG_OP_DOUBLE_DECREMENT_OP) ##1 1'b1 |->
      psw_reg[`DDIG_BIT_N] == ($past(cmd_byte) ? dst_reg[7] : dst_reg[15]))
    else $error("negative flag does not follow result sign");

  a_double_decrement_op_zero: assert property (
    s_exec_any(DDIG_OP_DOUBLE_DECREMENT_OP) |=>
      psw_reg[`DDIG_BIT_Z] ==
        ($past(cmd_byte) ? ($past(dst_reg[7:0]) == `DDIG_DOUBLE_DECREMENT_OP_B)
                         : ($past(dst_reg) == `DDIG_DOUBLE_DECREMENT_OP_W)))
    else $error("zero flag wrong after double-decrement");

  a_double_decrement_op_carry: assert property (
    s_exec(DDIG_OP_DOUBLE_DECREMENT_OP, 1'b0) |=>
      psw_reg[`DDIG_BIT_C] == ($past(dst_reg) > 16'h0001))
    else $error("carry flag wrong after double-decrement");

  // byte form borrows from bit 7, so only the low byte decides the carry
  a_double_decrement_op_carry_byte: assert property (
    s_exec(DDIG_OP_DOUBLE_DECREMENT_OP, 1'b1) |=>
      psw_reg[`DDIG_BIT_C] == ($past(dst_reg[7:0]) > 8'h01))
    else $error("byte carry flag wrong after double-decrement");

  a_ovf_word: assert property (
    s_exec(DDIG_OP_DOUBLE_DECREMENT_OP, 1'b0) |=>
      psw_reg[`DDIG_BIT_V] == (($past(dst_reg) == `DDIG_W_OVF_HI) ||
                               ($past(dst_reg) == `DDIG_W_OVF_LO)))
    else $error("word overflow flag wrong");

  a_ovf_byte: assert property (
    s_exec(DDIG_OP_DOUBLE_DECREMENT_OP, 1'b1) |=>
      psw_reg[`DDIG_BIT_V] == (($past(dst_reg[7:0]) == `DDIG_B_OVF_HI) ||
                               ($past(dst_reg[7:0]) == `DDIG_B_OVF_LO)))
    else $error("byte overflow flag wrong");

  a_double_decrement_op_mode_kept: assert property (
    s_exec_any(DDIG_OP_DOUBLE_DECREMENT_OP) |=>
      $stable(psw_reg[`DDIG_BIT_OSCILLATOR_OFF_BIT:`DDIG_BIT_GIE]))
    else $error("double-decrement touched mode bits");

  a_irq_disable_op_clear: assert property (
    s_exec_any(DDIG_OP_IRQ_DISABLE_OP) |=>
      (psw_reg == ($past(psw_reg) & ~`DDIG_GIE_MASK)))
    else $error("disable did not clear only the enable bit");

  a_irq_disable_op_mode_kept: assert property (
    s_exec_any(DDIG_OP_IRQ_DISABLE_OP) |=> !psw_reg[`DDIG_BIT_GIE] &&
      $stable(psw_reg[`DDIG_BIT_OSCILLATOR_OFF_BIT:`DDIG_BIT_CORE_OFF_BIT]))
    else $error("disable changed mode bits");

  a_irq_enable_op_set: assert property (
    s_exec_any(DDIG_OP_IRQ_ENABLE_OP) |=>
      (psw_reg == ($past(psw_reg) | `DDIG_GIE_MASK)))
    else $error("enable did not set only the enable bit");

  a_irq_enable_op_mode_kept: assert property (
    s_exec_any(DDIG_OP_IRQ_ENABLE_OP) |=> psw_reg[`DDIG_BIT_GIE] &&
      $stable(psw_reg[`DDIG_BIT_OSCILLATOR_OFF_BIT:`DDIG_BIT_CORE_OFF_BIT]))
    else $error("enable changed mode bits");

  a_gate_flags_kept: assert property (
    (cmd_fire && ((cmd_op == DDIG_OP_IRQ_DISABLE_OP) ||
                  (cmd_op == DDIG_OP_IRQ_ENABLE_OP))) |=>
      $stable(psw_reg[`DDIG_BIT_N:`DDIG_BIT_C]) &&
      $stable(psw_reg[`DDIG_BIT_V]))
    else $error("enable or disable changed arithmetic flags");

  a_irq_enable_op_shadow: assert property (
    s_exec_any(DDIG_OP_IRQ_ENABLE_OP) ##1 (!cmd_fire && !irq_accept_reg) |=>
      !irq_accept_reg)
    else $error("request accepted before next instruction ran");

  a_shadow_release: assert property (
    (cmd_fire && shadow_reg && (cmd_op != DDIG_OP_IRQ_ENABLE_OP)) ##1
      (CE && irq_pend_reg && psw_reg[`DDIG_BIT_GIE]) |=> irq_accept_reg)
    else $error("pending request not accepted after shadow");

  a_gie_gate: assert property (
    $rose(irq_accept_reg) |->
      $past(psw_reg[`DDIG_BIT_GIE]) && !$past(shadow_reg))
    else $error("request accepted while enable bit clear");

  a_apb_wait: assert property (
    (CE && access && !pready_reg) |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not one wait state");

endmodule // ddig_top
`default_nettype wire

// [verilog/ddig_stub_unused.sv]
// no further logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [test/ddig_tb.sv]
// self-checking bench for the double-decrement and interrupt gate unit
`timescale 1ns/100ps
`default_nettype none
`include "ddig_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb;
  import ddig_pkg::*;
  logic        REF_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        IRQ_REQ = 1'b0;
  logic        IRQ_ACCEPT;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] rnd = 32'd79954;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // ce is tied high: stretching the answer is not exercised here
  ddig_top dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CE(1'b1),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ_REQ(IRQ_REQ), .IRQ_ACCEPT(IRQ_ACCEPT));

  always #20 REF_CLK = ~REF_CLK;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer; the expectation is queued before the request goes out
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [31:0] ed,
                     input logic ee);
    exp_q.push_back({ee, ed});
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // only the bench timeout ends a stuck wait
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, d, 1'b0);
  endtask

  task automatic run_double_decrement_op(input logic [15:0] d, input logic byt,
                          input logic [15:0] p);
    logic [15:0] r;
    logic [15:0] q;
    logic [15:0] ps;
    q  = byt ? {8'h00, d[7:0]} : d;
    r  = byt ? {8'h00, d[7:0] - 8'h02} : d - 16'h0002;
    ps = p & ~16'h0107;
    ps[2] = byt ? r[7] : r[15];
    ps[1] = (q == 16'h0002);
    ps[0] = (q > 16'h0001);
    ps[8] = byt ? (q == 16'h0081 || q == 16'h0080)
                : (q == 16'h8001 || q == 16'h8000);
    wr(`DDIG_OFS_PSW, {16'h0, p});
    wr(`DDIG_OFS_DST, {16'h0, d});
    wr(`DDIG_OFS_CMD, {27'h0, byt, 4'h1});
    rd(`DDIG_OFS_DST, {16'h0, r});
    rd(`DDIG_OFS_PSW, {16'h0, ps});
  endtask

  task automatic run_gate(input logic [1:0] op, input logic [15:0] p);
    wr(`DDIG_OFS_PSW, {16'h0, p});
    wr(`DDIG_OFS_CMD, {30'h0, op});
    if (op == 2'h2) rd(`DDIG_OFS_PSW, {16'h0, p & ~16'h0008});
    else rd(`DDIG_OFS_PSW, {16'h0, p | 16'h0008});
  endtask

  // ---------------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(PSLVERR, e[32])
      if (!PWRITE) `CHK(PRDATA, e[31:0])
    end
  end

  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  logic [15:0] edge_w [9] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
    16'h8000, 16'h8001, 16'h8002, 16'h7fff, 16'hffff};
  logic [7:0]  edge_b [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80, 8'h81,
    8'h82, 8'h7f, 8'hff};

  initial begin
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
    rd(`DDIG_OFS_DST, 32'h0);
    rd(`DDIG_OFS_PSW, 32'h0);
    rd(`DDIG_OFS_STATE, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h20, 32'h1234, 32'h0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      run_double_decrement_op(edge_w[i], 1'b0, rnd[15:0] & 16'h013f);
      run_double_decrement_op({rnd[31:24], edge_b[i]}, 1'b1, rnd[23:8] & 16'h013f);
    end
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      run_double_decrement_op(rnd[15:0], rnd[16], rnd[31:16] & 16'h013f);
      run_gate(2'h2 + rnd[17], rnd[31:16] & 16'h013f);
    end
    run_gate(2'h2, 16'h0138);
    wr(`DDIG_OFS_CMD, 32'h0);
    IRQ_REQ <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    rd(`DDIG_OFS_STATE, 32'h2);
    `CHK(IRQ_ACCEPT, 1'b0)
    wr(`DDIG_OFS_CMD, 32'h3);
    rd(`DDIG_OFS_STATE, 32'h3);
    repeat (5) @(posedge REF_CLK);
    `CHK(IRQ_ACCEPT, 1'b0)
    wr(`DDIG_OFS_CMD, 32'h0);
    rd(`DDIG_OFS_STATE, 32'h6);
    `CHK(IRQ_ACCEPT, 1'b1)
    IRQ_REQ <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    wr(`DDIG_OFS_IRQACK, 32'h1);
    rd(`DDIG_OFS_STATE, 32'h0);
    `CHK(IRQ_ACCEPT, 1'b0)
    wrap_up();
  end
endmodule // tb
`default_nettype wire
